/* cpx_axil_slave.sv */
`timescale 1ns/1ns
module cpx_axil_slave
	import cpx_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write channels
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read channels
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Register side
	output logic reg_we,
	output logic [AXI_AW-1:0] reg_waddr,
	output logic [31:0] reg_wdata,
	output logic [3:0] reg_wstrb,
	input wire logic reg_werr,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rerr
);

	logic aw_held_r;
	logic w_held_r;

	// ------------------------------------------------
	// Write path: address and data in either order
	// ------------------------------------------------
	assign reg_we = aw_held_r && w_held_r && !s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			reg_waddr <= '0;
			reg_wdata <= 32'h00000000;
			reg_wstrb <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_r <= 1'b1;
				s_axi_awready <= 1'b0;
				reg_waddr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_r <= 1'b1;
				s_axi_wready <= 1'b0;
				reg_wdata <= s_axi_wdata;
				reg_wstrb <= s_axi_wstrb;
			end
			if (reg_we)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= reg_werr ? RESP_SLVERR : RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ------------------------------------------------
	// Read path: data sampled at the address handshake
	// ------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= reg_rdata;
			s_axi_rresp <= reg_rerr ? RESP_SLVERR : RESP_OKAY;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule : cpx_axil_slave

/* cpx_error_exit.sv */
// Contract
// - Out-of-range during opcodes 50..57 leaves destination operand register unchanged.
// - Compare/move range fault without exit mode does no memory access.
// - Monitor-mode fetch or branch beyond field length faults and exchanges.
// - Exit condition with its mode bit set writes code and address.
// - Exit condition with mode bit clear continues; bit is held pending.
// - A later error exit writes held bits with the causing bit.
// - Exchange to executive state discards held pending bits.
// - Software errors handled by executive state write code 00.
// - Hardware errors write only codes 20 or 67.
// - Diagnostic bits may fill the low 16 bits of the word.
// - Reference address and field length are 21-bit quantities.
// - Six flag bits sit in exchange word four, bits 56 down to 51.
// - Flags: extended memory, reserved, block copy, move interrupted, purge, hardware error.
// - Block copy and extended memory instructions illegal unless enable flag set; only ext_instr is checked here, block copy never made illegal.
// - Block copy flag takes address from operand register zero bits 30..50.
// - Interrupted compare/move sets its flag and saves resume state.
// - Reissued interrupted move or compare resumes from the saved point.
// - Purge flag selects extended purging of the lookahead stack.
// - Hardware error exits are always enabled and exchange to executive state.
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
module cpx_error_exit
	import cpx_pkg::*;
#(
	parameter int AW = ADDR_W
)
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pipeline events
	input wire logic monitor_mode,
	input wire logic instr_valid,
	input wire logic [5:0] instr_opcode,
	input wire logic address_range_violation,
	input wire logic [AW-1:0] program_address,
	input wire logic [COND_W-1:0] exit_cond_evt,
	input wire logic fetch_valid,
	input wire logic [AW-1:0] fetch_addr,
	input wire logic hw_error,
	input wire logic ext_instr,
	input wire logic [59:0] operand_register_zero,
	input wire logic [AW-1:0] address_register_zero,
	// Compare/move unit
	input wire logic cmu_start,
	input wire logic cmu_src_bad,
	input wire logic cmu_dst_bad,
	input wire logic cmu_interrupt,
	input wire logic [AW-1:0] cmu_progress,
	// Results
	output logic dest_write_en,
	output logic cmu_go,
	output logic cmu_mem_en,
	output logic cmu_resume,
	output logic [AW-1:0] cmu_resume_point,
	output logic illegal_instr,
	output logic [AW-1:0] block_copy_addr,
	output logic purge_extended,
	output logic exchange_req,
	// Reference address word write
	output logic ref_word_we,
	output logic [AW-1:0] ref_word_addr,
	output logic [COND_W-1:0] exit_condition_field,
	output logic [5:0] ref_word_code,
	output logic [AW-1:0] ref_word_pa,
	output logic [DIAG_W-1:0] ref_word_diag,
	output logic [59:0] xchg_word4
);

	// ------------------------------------------------
	// Elaboration check
	// ------------------------------------------------
	generate
		if (AW < 1 || AW > 32)
		begin : g_bad_aw
			$error("cpx_error_exit: AW must be 1..32");
		end
	endgenerate

	// ------------------------------------------------
	// State
	// ------------------------------------------------
	logic [FLAG_W-1:0] flags_r;
	logic [COND_W-1:0] exmode_r;
	logic [AW-1:0] ra_r;
	logic [AW-1:0] fl_r;
	logic [DIAG_W-1:0] diag_r;
	logic [COND_W-1:0] pend_r;
	logic [AW-1:0] saved_point_r;
	logic wb_en_r, cmu_go_r, cmu_mem_en_r, cmu_resume_r;
	logic [AW-1:0] cmu_point_r;
	logic illegal_r, purge_r, xchg_r, exw_valid_r;
	logic [AW-1:0] bc_addr_r;
	logic [COND_W-1:0] exw_cond_r;
	logic [5:0] exw_code_r;
	logic [AW-1:0] exw_pa_r;
	logic [DIAG_W-1:0] exw_diag_r;
	logic [59:0] word4_r;

	logic reg_we, reg_werr, reg_rerr;
	logic [AXI_AW-1:0] reg_waddr;
	logic [31:0] reg_wdata, reg_rdata, wmerged;
	logic [3:0] reg_wstrb;

	// ------------------------------------------------
	// Register bus
	// ------------------------------------------------
	cpx_axil_slave u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.reg_we(reg_we),
		.reg_waddr(reg_waddr),
		.reg_wdata(reg_wdata),
		.reg_wstrb(reg_wstrb),
		.reg_werr(reg_werr),
		.reg_rdata(reg_rdata),
		.reg_rerr(reg_rerr)
	);

	function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (s[i])
				r[i*8 +: 8] = d[i*8 +: 8];
		return r;
	endfunction : byte_merge

	always_comb
	begin
		case (reg_waddr)
			OFS_FLAGS: wmerged = byte_merge(32'(flags_r), reg_wdata, reg_wstrb);
			OFS_EXMODE: wmerged = byte_merge(32'(exmode_r), reg_wdata, reg_wstrb);
			OFS_RA: wmerged = byte_merge(32'(ra_r), reg_wdata, reg_wstrb);
			OFS_FL: wmerged = byte_merge(32'(fl_r), reg_wdata, reg_wstrb);
			default: wmerged = byte_merge(32'(diag_r), reg_wdata, reg_wstrb);
		endcase
		case (reg_waddr)
			OFS_FLAGS, OFS_EXMODE, OFS_RA, OFS_FL, OFS_DIAG,
			OFS_EXWORD, OFS_PEND, OFS_RESUME, OFS_EXPA: reg_werr = 1'b0;
			default: reg_werr = 1'b1;
		endcase
		reg_rerr = 1'b0;
		case (s_axi_araddr)
			OFS_FLAGS: reg_rdata = 32'(flags_r);
			OFS_EXMODE: reg_rdata = 32'(exmode_r);
			OFS_RA: reg_rdata = 32'(ra_r);
			OFS_FL: reg_rdata = 32'(fl_r);
			OFS_EXWORD: reg_rdata = 32'({exw_cond_r, exw_code_r});
			OFS_PEND: reg_rdata = 32'(pend_r);
			OFS_DIAG: reg_rdata = 32'(diag_r);
			OFS_RESUME: reg_rdata = 32'(saved_point_r);
			OFS_EXPA: reg_rdata = 32'(exw_pa_r);
			default:
			begin
				reg_rdata = 32'h00000000;
				reg_rerr = 1'b1;
			end
		endcase
	end

	// ------------------------------------------------
	// Event decode
	// ------------------------------------------------
	logic op_hold, cmu_bad, fetch_aor, exit_now, exch_now;
	logic [COND_W-1:0] cond_now, cond_taken;
	assign op_hold = instr_valid && address_range_violation
		&& instr_opcode >= OP_LO && instr_opcode <= OP_HI;
	assign cmu_bad = cmu_start && (cmu_src_bad || cmu_dst_bad);
	// Range checked here, not wrapped into installed memory
	assign fetch_aor = fetch_valid && monitor_mode && fetch_addr >= fl_r;
	always_comb
	begin
		cond_now = exit_cond_evt;
		cond_now[COND_ADDR] = exit_cond_evt[COND_ADDR] || cmu_bad || fetch_aor
			|| (instr_valid && address_range_violation);
		cond_taken = cond_now & exmode_r;
		cond_taken[COND_ADDR] = cond_taken[COND_ADDR] || fetch_aor;
	end
	assign exit_now = |cond_taken || hw_error;
	assign exch_now = (|cond_taken && monitor_mode) || hw_error;

	// ------------------------------------------------
	// Control and configuration registers
	// ------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			flags_r <= FLAGS_RST;
			exmode_r <= EXMODE_RST;
			ra_r <= '0;
			fl_r <= '0;
			diag_r <= '0;
			saved_point_r <= '0;
		end
		else
		begin
			if (cmu_start && flags_r[FB_CMUINT])
				flags_r[FB_CMUINT] <= 1'b0;
			if (reg_we)
			begin
				case (reg_waddr)
					OFS_FLAGS:
					begin
						flags_r <= wmerged[FLAG_W-1:0];
						flags_r[FB_RSVD] <= 1'b0;
					end
					OFS_EXMODE: exmode_r <= wmerged[COND_W-1:0];
					OFS_RA: ra_r <= wmerged[AW-1:0];
					OFS_FL: fl_r <= wmerged[AW-1:0];
					OFS_DIAG: diag_r <= wmerged[DIAG_W-1:0];
					default: ;
				endcase
			end
			// Hardware sets land after the software write so they are never lost
			if (hw_error)
				flags_r[FB_HWERR] <= 1'b1;
			if (cmu_interrupt)
			begin
				flags_r[FB_CMUINT] <= 1'b1;
				saved_point_r <= cmu_progress;
			end
		end
	end

	// ------------------------------------------------
	// Pending exit bits
	// ------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pend_r <= '0;
		else if (exch_now)
			pend_r <= '0;
		else if (exit_now)
			pend_r <= cond_now & ~exmode_r;
		else
			pend_r <= pend_r | (cond_now & ~exmode_r);
	end

	// ------------------------------------------------
	// Reference address word and exchange
	// ------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			exw_valid_r <= 1'b0;
			xchg_r <= 1'b0;
			exw_cond_r <= '0;
			exw_code_r <= CODE_SW;
			exw_pa_r <= '0;
			exw_diag_r <= '0;
		end
		else
		begin
			exw_valid_r <= exit_now;
			xchg_r <= exch_now;
			if (exit_now)
			begin
				exw_cond_r <= cond_taken | pend_r;
				exw_pa_r <= program_address;
				exw_diag_r <= diag_r;
				if (hw_error)
					exw_code_r <= monitor_mode ? CODE_HW_MON : CODE_HW_JOB;
				else
					exw_code_r <= CODE_SW;
			end
		end
	end

	// ------------------------------------------------
	// Instruction side effects
	// ------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wb_en_r <= 1'b0;
			illegal_r <= 1'b0;
			bc_addr_r <= '0;
			purge_r <= 1'b0;
			word4_r <= '0;
		end
		else
		begin
			// Old behaviour zeroed the register; now the write is suppressed
			wb_en_r <= instr_valid && !op_hold;
			illegal_r <= ext_instr && !flags_r[FB_EXTMEM];
			if (flags_r[FB_BCOPY])
				bc_addr_r <= AW'(operand_register_zero[X0_BC_MSB:X0_BC_LSB]);
			else
				bc_addr_r <= address_register_zero;
			purge_r <= flags_r[FB_PURGE];
			word4_r <= '0;
			word4_r[XW_FLAG_MSB:XW_FLAG_LSB] <= flags_r;
		end
	end

	// ------------------------------------------------
	// Compare/move control
	// ------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cmu_go_r <= 1'b0;
			cmu_mem_en_r <= 1'b0;
			cmu_resume_r <= 1'b0;
			cmu_point_r <= '0;
		end
		else
		begin
			cmu_go_r <= cmu_start;
			if (cmu_start)
			begin
				cmu_mem_en_r <= !cmu_bad;
				cmu_resume_r <= flags_r[FB_CMUINT];
				cmu_point_r <= flags_r[FB_CMUINT] ? saved_point_r : '0;
			end
		end
	end

	assign dest_write_en = wb_en_r;
	assign cmu_go = cmu_go_r;
	assign cmu_mem_en = cmu_mem_en_r;
	assign cmu_resume = cmu_resume_r;
	assign cmu_resume_point = cmu_point_r;
	assign illegal_instr = illegal_r;
	assign block_copy_addr = bc_addr_r;
	assign purge_extended = purge_r;
	assign exchange_req = xchg_r;
	assign ref_word_we = exw_valid_r;
	assign ref_word_addr = ra_r;
	assign exit_condition_field = exw_cond_r;
	assign ref_word_code = exw_code_r;
	assign ref_word_pa = exw_pa_r;
	assign ref_word_diag = exw_diag_r;
	assign xchg_word4 = word4_r;

	// ------------------------------------------------
	// Assertions
	// ------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_dest_kept: assert property (op_hold |=> !wb_en_r) else $error("dest written on range fault");
	a_cmu_nomem: assert property (cmu_bad |=> !cmu_mem_en_r && cmu_go_r) else $error("cmu accessed memory");
	a_fetch_exch: assert property (fetch_aor |=> xchg_r && exw_cond_r[COND_ADDR]) else $error("fetch fault missed");
	a_exit_write: assert property (|(exit_cond_evt & exmode_r) |=> exw_valid_r) else $error("exit not written");
	a_pend_hold: assert property (exit_cond_evt != 0 && !exit_now |=> (pend_r & $past(exit_cond_evt)) == $past(exit_cond_evt)) else $error("pending bit lost");
	a_pend_flush: assert property (exit_now && !exch_now && pend_r != 0 |=> (exw_cond_r & $past(pend_r)) == $past(pend_r) && pend_r == $past(cond_now & ~exmode_r)) else $error("pending not written");
	a_pend_drop: assert property (xchg_r |-> pend_r == 0) else $error("pending kept over exchange");
	a_sw_code: assert property (exit_now && !hw_error |=> exw_code_r == CODE_SW) else $error("bad software code");
	a_hw_code: assert property (hw_error |=> exw_code_r == CODE_HW_MON || exw_code_r == CODE_HW_JOB) else $error("bad hardware code");
	a_rsvd_zero: assert property (flags_r[FB_RSVD] == 1'b0) else $error("reserved flag set");
	a_illegal_ext: assert property (ext_instr && !flags_r[FB_EXTMEM] |=> illegal_r) else $error("ext instr not illegal");
	a_hw_exch: assert property (hw_error |=> xchg_r && flags_r[FB_HWERR] ##1 !xchg_r || $past(hw_error) || exch_now) else $error("hw error no exchange");
	a_cmu_flag: assert property (cmu_start && flags_r[FB_CMUINT] |=> cmu_resume_r && cmu_point_r == $past(saved_point_r)) else $error("no resume");

	c_exit_pend: cover property (pend_r != 0 ##[1:40] exw_valid_r);
	c_hw_exch: cover property (hw_error ##1 xchg_r);
	c_cmu_resume: cover property (cmu_interrupt ##[1:40] cmu_resume_r);

endmodule : cpx_error_exit

/* cpx_exec_model.sv */
`timescale 1ns/1ns
module cpx_exec_model
	import cpx_pkg::*;
(
	// Clock
	input wire logic aclk,
	// Flag image built by executive software
	input wire logic [FLAG_W-1:0] flag_want,
	output logic [FLAG_W-1:0] flag_image,
	// Reference word as stored in central memory
	input wire logic ref_word_we,
	input wire logic [5:0] ref_word_code,
	input wire logic [COND_W-1:0] exit_condition_field,
	input wire logic [ADDR_W-1:0] ref_word_pa,
	output logic [5:0] mem_code,
	output logic [COND_W-1:0] mem_cond,
	output logic [ADDR_W-1:0] mem_pa
);
	// Reserved bit is never offered, whatever the caller asks for
	assign flag_image = flag_want & ~(6'h01 << FB_RSVD);

	// Memory only changes on a write strobe, so stale words stay visible
	always @(posedge aclk)
	begin
		if (ref_word_we)
			{mem_code, mem_cond, mem_pa} <= {ref_word_code, exit_condition_field, ref_word_pa};
	end
endmodule : cpx_exec_model

/* cpx_pkg.sv */
package cpx_pkg;

	// ------------------------------------------------
	// Widths
	// ------------------------------------------------
	localparam int ADDR_W = 21;
	localparam int AXI_AW = 8;
	localparam int COND_W = 3;
	localparam int DIAG_W = 16;
	localparam int FLAG_W = 6;

	// ------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------
	localparam logic [7:0] OFS_FLAGS = 8'h00;
	localparam logic [7:0] OFS_EXMODE = 8'h04;
	localparam logic [7:0] OFS_RA = 8'h08;
	localparam logic [7:0] OFS_FL = 8'h0c;
	localparam logic [7:0] OFS_EXWORD = 8'h10;
	localparam logic [7:0] OFS_PEND = 8'h14;
	localparam logic [7:0] OFS_DIAG = 8'h18;
	localparam logic [7:0] OFS_RESUME = 8'h1c;
	localparam logic [7:0] OFS_EXPA = 8'h20;

	// ------------------------------------------------
	// Flag field positions and exchange word placement
	// ------------------------------------------------
	localparam int FB_HWERR = 0;
	localparam int FB_PURGE = 1;
	localparam int FB_CMUINT = 2;
	localparam int FB_BCOPY = 3;
	localparam int FB_RSVD = 4;
	localparam int FB_EXTMEM = 5;
	localparam int XW_FLAG_LSB = 51;
	localparam int XW_FLAG_MSB = 56;
	localparam int X0_BC_LSB = 30;
	localparam int X0_BC_MSB = 50;

	// ------------------------------------------------
	// Codes and reset values
	// ------------------------------------------------
	localparam int COND_ADDR = 0;
	localparam logic [5:0] OP_LO = 6'h28;
	localparam logic [5:0] OP_HI = 6'h2f;
	localparam logic [5:0] CODE_SW = 6'h00;
	localparam logic [5:0] CODE_HW_JOB = 6'h10;
	localparam logic [5:0] CODE_HW_MON = 6'h37;
	localparam logic [FLAG_W-1:0] FLAGS_RST = 6'h00;
	localparam logic [COND_W-1:0] EXMODE_RST = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : cpx_pkg

/* test_cp_error_exit_and_flag_register.sv */
`timescale 1ns/1ns
module test_cp_error_exit_and_flag_register
	import cpx_pkg::*;
;
	// ------------------------------------------------
	// Signals
	// ------------------------------------------------
	logic aclk, aresetn;
	logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic monitor_mode, instr_valid, address_range_violation, fetch_valid, hw_error, ext_instr;
	logic cmu_start, cmu_src_bad, cmu_dst_bad, cmu_interrupt;
	logic [5:0] instr_opcode, ref_word_code, mem_code;
	logic [ADDR_W-1:0] program_address, fetch_addr, address_register_zero, cmu_progress, mem_pa;
	logic [ADDR_W-1:0] cmu_resume_point, block_copy_addr, ref_word_addr, ref_word_pa;
	logic [COND_W-1:0] exit_cond_evt, exit_condition_field, mem_cond;
	logic [59:0] operand_register_zero, xchg_word4;
	logic dest_write_en, cmu_go, cmu_mem_en, cmu_resume, illegal_instr, purge_extended;
	logic exchange_req, ref_word_we;
	logic [DIAG_W-1:0] ref_word_diag;
	logic [FLAG_W-1:0] flag_image;
	int num_errors, checks, cyc;

	cpx_error_exit i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .monitor_mode, .instr_valid, .instr_opcode, .address_range_violation,
		.program_address, .exit_cond_evt, .fetch_valid, .fetch_addr, .hw_error, .ext_instr,
		.operand_register_zero, .address_register_zero, .cmu_start, .cmu_src_bad, .cmu_dst_bad,
		.cmu_interrupt, .cmu_progress, .dest_write_en, .cmu_go, .cmu_mem_en, .cmu_resume,
		.cmu_resume_point, .illegal_instr, .block_copy_addr, .purge_extended, .exchange_req,
		.ref_word_we, .ref_word_addr, .exit_condition_field, .ref_word_code, .ref_word_pa,
		.ref_word_diag, .xchg_word4);
	cpx_exec_model i_mem (.aclk, .flag_want(6'h3f), .flag_image, .ref_word_we, .ref_word_code,
		.exit_condition_field, .ref_word_pa, .mem_code, .mem_cond, .mem_pa);

	// ------------------------------------------------
	// Tasks
	// ------------------------------------------------
	task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic complete_run;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run

	// Pulses drop at the edge that samples them; outputs are read after it lands
	task automatic settle;
		@(posedge aclk);
		{instr_valid, fetch_valid, hw_error, ext_instr, cmu_start, cmu_interrupt} <= 6'h00;
		exit_cond_evt <= 3'h0;
		#1;
	endtask : settle

	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
		forever
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axw

	task automatic axr(input logic [7:0] a);
		@(posedge aclk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		forever
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		{rd, rsp} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
	endtask : axr

	task automatic t_regs;
		axr(OFS_EXMODE);
		chk("exmode", rd, 32'h0);
		axw(OFS_RA, 32'hffffffff);
		axr(OFS_RA);
		chk("ra", rd, 32'h001fffff);
		chk("ref_addr", ref_word_addr, 21'h1fffff);
		axw(OFS_FLAGS, {26'h0, flag_image});
		axr(OFS_FLAGS);
		chk("flags", rd, 32'h2f);
		chk("xword", xchg_word4, {3'h0, 6'h2f, 51'h0});
		chk("purge", purge_extended, 1'h1);
		chk("bc_addr", block_copy_addr, 21'h0abcde);
		@(posedge aclk);
		ext_instr <= 1'b1;
		settle;
		chk("illegal", illegal_instr, 1'h0);
		axw(OFS_FLAGS, 32'h0);
		axr(OFS_FLAGS);
		chk("purge", purge_extended, 1'h0);
		chk("bc_addr", block_copy_addr, 21'h111111);
		@(posedge aclk);
		ext_instr <= 1'b1;
		settle;
		chk("illegal", illegal_instr, 1'h1);
		axr(8'h40);
		chk("rd_resp", rsp, 2'h2);
		axw(8'h40, 32'h1);
		chk("wr_resp", rsp, 2'h2);
	endtask : t_regs

	task automatic t_dest;
		for (logic [5:0] op = 6'h27; op <= 6'h30; op++)
		begin
			@(posedge aclk);
			{instr_valid, instr_opcode, address_range_violation} <= {1'b1, op, 1'b1};
			settle;
			chk("dest_we", dest_write_en, op < 6'h28 || op > 6'h2f);
		end
		@(posedge aclk);
		{instr_valid, instr_opcode, address_range_violation} <= {1'b1, 6'h2a, 1'b0};
		settle;
		chk("dest_we", dest_write_en, 1'h1);
	endtask : t_dest

	task automatic t_cmu;
		@(posedge aclk);
		{cmu_start, cmu_src_bad} <= 2'h3;
		settle;
		chk("go", cmu_go, 1'h1);
		chk("mem_en", cmu_mem_en, 1'h0);
		@(posedge aclk);
		{cmu_start, cmu_src_bad, cmu_dst_bad} <= 3'h5;
		settle;
		chk("mem_en", cmu_mem_en, 1'h0);
		@(posedge aclk);
		{cmu_start, cmu_dst_bad} <= 2'h2;
		settle;
		chk("mem_en", cmu_mem_en, 1'h1);
		chk("resume", cmu_resume, 1'h0);
		@(posedge aclk);
		{cmu_interrupt, cmu_progress} <= {1'b1, 21'h000777};
		settle;
		axr(OFS_FLAGS);
		chk("int_flag", rd[FB_CMUINT], 1'h1);
		axr(OFS_RESUME);
		chk("saved", rd, 32'h777);
		@(posedge aclk);
		cmu_start <= 1'b1;
		settle;
		chk("resume", cmu_resume, 1'h1);
		chk("point", cmu_resume_point, 21'h000777);
	endtask : t_cmu

	task automatic t_fetch;
		axw(OFS_FL, 32'h100);
		@(posedge aclk);
		{monitor_mode, fetch_valid, fetch_addr} <= {2'h3, 21'h0000ff};
		settle;
		chk("xchg", exchange_req, 1'h0);
		@(posedge aclk);
		{fetch_valid, fetch_addr} <= {1'b1, 21'h000100};
		settle;
		chk("xchg", exchange_req, 1'h1);
		chk("ref_we", ref_word_we, 1'h1);
		@(posedge aclk);
		monitor_mode <= 1'b0;
	endtask : t_fetch

	task automatic t_exit;
		axw(OFS_DIAG, 32'h0000beef);
		@(posedge aclk);
		exit_cond_evt <= 3'h2;
		settle;
		chk("ref_we", ref_word_we, 1'h0);
		axr(OFS_PEND);
		chk("pend", rd, 32'h2);
		axw(OFS_EXMODE, 32'h1);
		@(posedge aclk);
		{exit_cond_evt, program_address} <= {3'h1, 21'h012345};
		settle;
		chk("ref_we", ref_word_we, 1'h1);
		chk("cond", exit_condition_field, 3'h3);
		chk("code", ref_word_code, 6'h00);
		chk("diag", ref_word_diag, 16'hbeef);
		@(posedge aclk);
		#1;
		chk("mem_pa", mem_pa, 21'h012345);
		chk("mem_cond", mem_cond, 3'h3);
		@(posedge aclk);
		exit_cond_evt <= 3'h2;
		settle;
		@(posedge aclk);
		hw_error <= 1'b1;
		settle;
		chk("xchg", exchange_req, 1'h1);
		chk("code", ref_word_code, 6'h10);
		axr(OFS_FLAGS);
		chk("hw_flag", rd[FB_HWERR], 1'h1);
		@(posedge aclk);
		exit_cond_evt <= 3'h1;
		settle;
		chk("cond", exit_condition_field, 3'h1);
		axw(OFS_EXMODE, 32'h0);
		@(posedge aclk);
		{monitor_mode, hw_error} <= 2'h3;
		settle;
		chk("xchg", exchange_req, 1'h1);
		chk("code", ref_word_code, 6'h37);
	endtask : t_exit

	// ------------------------------------------------
	// Sequence
	// ------------------------------------------------
	initial
	begin
		aclk = 1'b0;
		forever
			#25 aclk = ~aclk;
	end

	// Whole run needs about 120 cycles; the ceiling leaves wide margin
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			complete_run;
		end
	end

	initial
	begin
		{aresetn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready, monitor_mode, instr_valid, instr_opcode} = '0;
		{address_range_violation, program_address, exit_cond_evt, fetch_valid, fetch_addr} = '0;
		{hw_error, ext_instr, cmu_start, cmu_src_bad, cmu_dst_bad, cmu_interrupt, cmu_progress} = '0;
		s_axi_wstrb = 4'hf;
		operand_register_zero = {9'h0, 21'h0abcde, 30'h0};
		address_register_zero = 21'h111111;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_dest;
		t_cmu;
		t_fetch;
		t_exit;
		complete_run;
	end
endmodule : test_cp_error_exit_and_flag_register
